//--- rtl/lcs_pkg.sv
// Shared constants, register map and carrier types of the loop-current setpoint block.
// Assumes a 250 MHz system clock and a 32-bit classic Wishbone register port.

package lcs_pkg;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_POLL = 8'h04;
    localparam logic [7:0] OFS_RLO = 8'h08;
    localparam logic [7:0] OFS_RHI = 8'h0c;
    localparam logic [7:0] OFS_LINK = 8'h10;
    localparam logic [7:0] OFS_STORE = 8'h14;
    localparam logic [7:0] OFS_MAP = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1c;
    localparam logic [7:0] OFS_PV = 8'h20;
    // Slot blocks: adr[7:5] selects block, adr[4:2] the slot
    localparam logic [2:0] BLK_SRC = 3'h2;
    localparam logic [2:0] BLK_DVV = 3'h3;

    // ----------------------------------------
    // Sizes, limits, field positions
    // ----------------------------------------
    localparam logic [2:0] NUM_SLOTS = 3'h6;
    localparam int NUM_DYN = 4;
    localparam int MAP_STRIDE = 4;
    localparam int CTRL_ALARM_BIT = 0;
    localparam logic [31:0] SRC_MAX = 32'h00010000;
    localparam int NUM_W = 46;
    localparam logic [5:0] DIV_STEPS = 6'h2e;
    localparam int LED_CNT_W = 24;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [5:0] RST_POLL = 6'h00;
    localparam logic [31:0] RST_RLO = 32'h00000000;
    localparam logic [31:0] RST_RHI = 32'h00002710;
    localparam logic [13:0] RST_LINK = 14'h1301;
    localparam logic [4:0] RST_STORE = 5'h00;
    localparam logic [11:0] RST_MAP = 12'h688;

    // ----------------------------------------
    // Loop currents in microamps
    // ----------------------------------------
    localparam logic [15:0] CUR_LOW = 16'h0fa0;
    localparam logic [15:0] CUR_SPAN = 16'h3e80;
    localparam logic [15:0] CUR_HIGH = 16'h4e20;
    localparam logic [15:0] CUR_SAT_HI = 16'h5140;
    localparam logic [15:0] CUR_SAT_LO = 16'h0ed8;
    localparam logic [15:0] CUR_ALM_HI = 16'h54f6;
    localparam logic [15:0] CUR_ALM_LO = 16'h0e74;
    localparam logic [15:0] CUR_MULTI = 16'h0fa0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_MHZ = 32'h000000fa;
    localparam int unsigned LED_HOLD_US = 32'h0000c350;
    localparam int unsigned LED_HOLD_CYC = LED_HOLD_US * CLK_MHZ;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic crc_hi_first;
        logic [1:0] parity;
        logic [2:0] rate;
        logic [7:0] slave_addr;
    } lcs_link_cfg_t;

    typedef struct packed {
        logic [1:0] order;
        logic [2:0] dtype;
    } lcs_store_cfg_t;

    typedef struct packed {
        logic valid;
        logic [16:0] addr;
        logic [31:0] data;
    } lcs_acq_t;

    typedef struct packed {
        logic [31:0] fourth_variable;
        logic [31:0] third_variable;
        logic [31:0] second_variable;
        logic [31:0] primary_variable;
    } lcs_dyn_t;

    typedef enum logic [1:0] {RG_IN, RG_EQ_HI, RG_OVER, RG_UNDER} lcs_region_t;
    typedef enum logic {ST_IDLE, ST_BUSY} lcs_state_t;

endpackage

//--- rtl/lcs_div.sv
// Restoring divider for the proportional span.
// Assumes start is only raised while the previous division is finished.

`timescale 1ns/1ps
`default_nettype none

module lcs_div
    import lcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [NUM_W-1:0] num_i,
    input wire logic [31:0] den_i,
    output logic done_o,
    output logic [15:0] quo_o
);

    // Dividend shifts out on top while quotient bits shift in below
    logic [NUM_W-1:0] num_reg;
    logic [32:0] rem_reg;
    logic [31:0] den_reg;
    logic [5:0] cnt_reg;
    logic busy_reg;
    logic done_reg;

    wire [32:0] trial = {rem_reg[31:0], num_reg[NUM_W-1]};
    wire fits = trial >= {1'b0, den_reg};
    wire [32:0] rem_next = fits ? trial - {1'b0, den_reg} : trial;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            num_reg <= '0;
            rem_reg <= '0;
            den_reg <= '0;
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= busy_reg && cnt_reg == 6'h01;
            if (start_i && !busy_reg) begin
                num_reg <= num_i;
                den_reg <= den_i;
                rem_reg <= '0;
                cnt_reg <= DIV_STEPS;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                num_reg <= {num_reg[NUM_W-2:0], fits};
                rem_reg <= rem_next;
                cnt_reg <= cnt_reg - 6'h01;
                busy_reg <= cnt_reg != 6'h01;
            end
        end
    end

    assign done_o = done_reg;
    assign quo_o = num_reg[15:0];

endmodule

`default_nettype wire

//--- rtl/lcs_top.sv
// Loop-current setpoint logic: range compare, saturation, alarm, multidrop.
// Assumes a classic Wishbone master and a register-link engine on clk_i.

`timescale 1ns/1ps
`default_nettype none

module lcs_top
    import lcs_pkg::*;
#(
    parameter int unsigned LED_HOLD = LED_HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire lcs_acq_t acq_i,
    input wire logic fault_i,
    input wire logic link_act_i,
    input wire logic loop_act_i,
    output lcs_link_cfg_t link_cfg_o,
    output lcs_store_cfg_t store_cfg_o,
    output lcs_dyn_t dyn_o,
    output logic [15:0] setpoint_o,
    output logic link_led_n_o,
    output logic loop_led_n_o
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [31:0] order_fix(input logic [31:0] w, input logic [1:0] o);
        case (o)
            2'h1: order_fix = {w[7:0], w[15:8], w[23:16], w[31:24]};
            2'h2: order_fix = {w[23:16], w[31:24], w[7:0], w[15:8]};
            2'h3: order_fix = {w[15:0], w[31:16]};
            default: order_fix = w;
        endcase
    endfunction

    function automatic logic slot_ok(input logic [3:0] s);
        slot_ok = s < {1'b0, NUM_SLOTS};
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic alarm_hi_reg;
    logic [5:0] poll_reg;
    logic signed [31:0] rlo_reg;
    logic signed [31:0] rhi_reg;
    lcs_link_cfg_t link_reg;
    lcs_store_cfg_t store_reg;
    logic [2:0] map_reg [NUM_DYN];
    logic [16:0] src_reg [NUM_SLOTS];
    logic [31:0] slot_reg [NUM_SLOTS];
    logic [31:0] dyn_reg [NUM_DYN];
    logic fault_reg;
    lcs_state_t state_reg;
    lcs_region_t region_reg;
    lcs_region_t region_snap_reg;
    logic [15:0] prop_reg;
    logic [15:0] setpoint_reg;
    logic [1:0] led_n_reg;
    logic [LED_CNT_W-1:0] led_cnt_reg [2];

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire req = wb_cyc_i & wb_stb_i;
    wire wr_en = req & wb_we_i & ack_reg & (wb_sel_i == 4'hf);
    wire [2:0] slot_idx = wb_adr_i[4:2];
    wire slot_hit = slot_ok({1'b0, slot_idx}) & (wb_adr_i[1:0] == 2'h0);
    wire hit_src = (wb_adr_i[7:5] == BLK_SRC) & slot_hit;
    wire hit_dvv = (wb_adr_i[7:5] == BLK_DVV) & slot_hit;
    wire wr_ctrl = wr_en & (wb_adr_i == OFS_CTRL);
    wire wr_poll = wr_en & (wb_adr_i == OFS_POLL);
    wire wr_rlo = wr_en & (wb_adr_i == OFS_RLO);
    wire wr_rhi = wr_en & (wb_adr_i == OFS_RHI);
    wire wr_link = wr_en & (wb_adr_i == OFS_LINK);
    wire wr_store = wr_en & (wb_adr_i == OFS_STORE);
    wire wr_map = wr_en & (wb_adr_i == OFS_MAP);
    wire wr_src = wr_en & hit_src;
    // Out-of-range values are dropped so a bad write cannot corrupt state
    wire poll_ok = wb_dat_i[31:6] == 26'h0;
    wire src_ok = (wb_dat_i != 32'h0) && (wb_dat_i <= SRC_MAX);

    wire [31:0] stat_word = {13'h0, region_reg, fault_reg, setpoint_reg};
    wire [31:0] map_word = {16'h0, 1'b0, map_reg[3], 1'b0, map_reg[2],
                            1'b0, map_reg[1], 1'b0, map_reg[0]};
    wire [31:0] rd_word =
        (wb_adr_i == OFS_CTRL) ? {31'h0, alarm_hi_reg} :
        (wb_adr_i == OFS_POLL) ? {26'h0, poll_reg} :
        (wb_adr_i == OFS_RLO) ? rlo_reg :
        (wb_adr_i == OFS_RHI) ? rhi_reg :
        (wb_adr_i == OFS_LINK) ? {18'h0, link_reg} :
        (wb_adr_i == OFS_STORE) ? {27'h0, store_reg} :
        (wb_adr_i == OFS_MAP) ? map_word :
        (wb_adr_i == OFS_STAT) ? stat_word :
        (wb_adr_i == OFS_PV) ? dyn_reg[0] :
        hit_src ? {15'h0, src_reg[slot_idx]} :
        hit_dvv ? slot_reg[slot_idx] : 32'h0;

    // ----------------------------------------
    // Bus slave: one-cycle registered answer
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
        end else begin
            ack_reg <= req & ~ack_reg;
            rdat_reg <= rd_word;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_hi_reg <= 1'b0;
            poll_reg <= RST_POLL;
            rlo_reg <= RST_RLO;
            rhi_reg <= RST_RHI;
            link_reg <= RST_LINK;
            store_reg <= RST_STORE;
        end else begin
            if (wr_ctrl) begin
                alarm_hi_reg <= wb_dat_i[CTRL_ALARM_BIT];
            end
            if (wr_poll && poll_ok) begin
                poll_reg <= wb_dat_i[5:0];
            end
            if (wr_rlo) begin
                rlo_reg <= wb_dat_i;
            end
            if (wr_rhi) begin
                rhi_reg <= wb_dat_i;
            end
            if (wr_link) begin
                link_reg <= wb_dat_i[13:0];
            end
            if (wr_store) begin
                store_reg <= wb_dat_i[4:0];
            end
        end
    end

    // ----------------------------------------
    // Variable slots and dynamic assignment
    // ----------------------------------------
    wire [31:0] acq_word = order_fix(acq_i.data, store_reg.order);

    generate
        for (genvar k = 0; k < NUM_SLOTS; k++) begin : g_slot
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    src_reg[k] <= 17'h0;
                    slot_reg[k] <= 32'h0;
                end else begin
                    if (wr_src && slot_idx == k && src_ok) begin
                        src_reg[k] <= wb_dat_i[16:0];
                    end
                    // Zero source means unbound; the link never reports address 0
                    if (acq_i.valid && acq_i.addr == src_reg[k]) begin
                        slot_reg[k] <= acq_word;
                    end
                end
            end
        end
        for (genvar d = 0; d < NUM_DYN; d++) begin : g_dyn
            wire [3:0] fld = wb_dat_i[MAP_STRIDE*d +: MAP_STRIDE];
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    map_reg[d] <= RST_MAP[3*d +: 3];
                    dyn_reg[d] <= 32'h0;
                end else begin
                    if (wr_map && slot_ok(fld)) begin
                        map_reg[d] <= fld[2:0];
                    end
                    dyn_reg[d] <= slot_reg[map_reg[d]];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Range compare and proportional span
    // ----------------------------------------
    wire signed [31:0] pv_val = dyn_reg[0];
    wire [31:0] pv_diff = pv_val - rlo_reg;
    wire [31:0] span_den = rhi_reg - rlo_reg;
    wire [NUM_W-1:0] span_num = NUM_W'(pv_diff) * NUM_W'(CUR_SPAN);
    wire lcs_region_t region_now =
        (pv_val == rhi_reg) ? RG_EQ_HI :
        (pv_val > rhi_reg) ? RG_OVER :
        (pv_val < rlo_reg) ? RG_UNDER : RG_IN;
    wire div_start = state_reg == ST_IDLE;
    wire div_done;
    wire [15:0] div_quo;

    lcs_div u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(div_start),
        .num_i(span_num),
        .den_i(span_den),
        .done_o(div_done),
        .quo_o(div_quo)
    );

    // Region and span are taken from one snapshot so they never disagree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            region_snap_reg <= RG_IN;
            region_reg <= RG_IN;
            prop_reg <= CUR_LOW;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    region_snap_reg <= region_now;
                    state_reg <= ST_BUSY;
                end
                ST_BUSY: begin
                    if (div_done) begin
                        region_reg <= region_snap_reg;
                        prop_reg <= CUR_LOW + div_quo;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Current selection
    // ----------------------------------------
    wire [15:0] region_cur =
        (region_reg == RG_EQ_HI) ? CUR_HIGH :
        (region_reg == RG_OVER) ? CUR_SAT_HI :
        (region_reg == RG_UNDER) ? CUR_SAT_LO : prop_reg;
    wire [15:0] alarm_cur = alarm_hi_reg ? CUR_ALM_HI : CUR_ALM_LO;
    // Fault and polling address act at once, without waiting for a division
    wire [15:0] setpoint_next =
        fault_i ? alarm_cur :
        (poll_reg != 6'h0) ? CUR_MULTI : region_cur;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            setpoint_reg <= CUR_LOW;
            fault_reg <= 1'b0;
        end else begin
            setpoint_reg <= setpoint_next;
            fault_reg <= fault_i;
        end
    end

    // ----------------------------------------
    // Activity indicators
    // ----------------------------------------
    wire [1:0] act = {loop_act_i, link_act_i};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_led
            wire busy = led_cnt_reg[i] != '0;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    led_cnt_reg[i] <= '0;
                    led_n_reg[i] <= 1'b1;
                end else begin
                    // Stretch so a short frame stays visible
                    if (act[i]) begin
                        led_cnt_reg[i] <= LED_CNT_W'(LED_HOLD - 1);
                    end else if (busy) begin
                        led_cnt_reg[i] <= led_cnt_reg[i] - 1'b1;
                    end
                    led_n_reg[i] <= ~(act[i] | busy);
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign link_cfg_o = link_reg;
    assign store_cfg_o = store_reg;
    assign dyn_o = {dyn_reg[3], dyn_reg[2], dyn_reg[1], dyn_reg[0]};
    assign setpoint_o = setpoint_reg;
    assign link_led_n_o = led_n_reg[0];
    assign loop_led_n_o = led_n_reg[1];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    wire [31:0] pv_src = slot_reg[map_reg[0]];

    a_alarm_high: assert property (
        fault_i && alarm_hi_reg |=> setpoint_o == CUR_ALM_HI)
        else $error("High alarm current not driven");
    a_alarm_low: assert property (
        fault_i && !alarm_hi_reg |=> setpoint_o == CUR_ALM_LO)
        else $error("Low alarm current not driven");
    a_multidrop_fixed: assert property (
        !fault_i && poll_reg != 6'h0 |=> setpoint_o == CUR_MULTI)
        else $error("Multidrop current not fixed");
    a_sat_over: assert property (
        !fault_i && poll_reg == 6'h0 && region_reg == RG_OVER |=> setpoint_o == CUR_SAT_HI)
        else $error("Upper saturation current wrong");
    a_sat_under: assert property (
        !fault_i && poll_reg == 6'h0 && region_reg == RG_UNDER |=> setpoint_o == CUR_SAT_LO)
        else $error("Lower saturation current wrong");
    a_upper_equal: assert property (
        !fault_i && poll_reg == 6'h0 && region_reg == RG_EQ_HI |=> setpoint_o == CUR_HIGH)
        else $error("Upper limit current wrong");
    a_span_bounds: assert property (
        !fault_i && poll_reg == 6'h0 && region_reg == RG_IN
        |=> setpoint_o >= CUR_LOW && setpoint_o <= CUR_HIGH)
        else $error("Proportional current out of span");
    a_compare_period: assert property (
        div_start |-> ##[1:60] div_done)
        else $error("Range compare stalled");
    a_poll_reject: assert property (
        wr_poll && !poll_ok |=> $stable(poll_reg))
        else $error("Polling address above 63 accepted");
    a_slot_refresh: assert property (
        acq_i.valid && src_reg[0] != 17'h0 && acq_i.addr == src_reg[0]
        |=> slot_reg[0] == $past(acq_word))
        else $error("Bound slot not refreshed");
    a_primary_map: assert property (
        ##1 dyn_reg[0] == $past(pv_src))
        else $error("Primary variable not following its slot");
    a_link_led: assert property (
        link_act_i |=> !link_led_n_o)
        else $error("Register-link indicator not lit");
    a_loop_led: assert property (
        loop_act_i |=> !loop_led_n_o)
        else $error("Field-loop indicator not lit");
    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Bus answer longer than one cycle");

    c_fault_alarm: cover property (fault_i ##1 setpoint_o == CUR_ALM_HI);
    c_over_range: cover property (region_reg == RG_OVER && poll_reg == 6'h0);
    c_multidrop: cover property (poll_reg != 6'h0 && !fault_i);
    c_span_done: cover property (div_done && region_snap_reg == RG_IN);

endmodule

`default_nettype wire

//--- verification/lcs_dac_model.sv
// Behavioural loop-current output stage at the far side of the setpoint.
// Assumes the setpoint arrives in microamps on the block's own clock.
`timescale 1ns/1ps
`default_nettype none
module lcs_dac_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] code_i,
    output logic [15:0] ua_o
);
    // One register stands in for output settling, so checks see a real lag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ua_o <= 16'h0000;
        end else begin
            ua_o <= code_i;
        end
    end
endmodule
`default_nettype wire

//--- verification/lcs_top_tb.sv
// Self-checking bench of the loop-current setpoint block.
// Assumes lcs_top on one clock and the behavioural output stage.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
 $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); err_count++; end end
module lcs_top_tb;
    import lcs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    lcs_acq_t acq = '0;
    logic fault = 1'b0;
    logic lact = 1'b0;
    logic pact = 1'b0;
    lcs_link_cfg_t lcfg;
    lcs_store_cfg_t scfg;
    lcs_dyn_t dyn;
    logic [15:0] sp;
    logic [15:0] ua;
    logic lled_n;
    logic pled_n;
    logic [31:0] q;
    int err_count = 0;
    int checks = 0;
    initial forever #2 clk_i = ~clk_i;
    // Short indicator hold keeps the indicator test brief
    lcs_top #(.LED_HOLD(8)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .acq_i(acq), .fault_i(fault),
        .link_act_i(lact), .loop_act_i(pact), .link_cfg_o(lcfg),
        .store_cfg_o(scfg), .dyn_o(dyn), .setpoint_o(sp),
        .link_led_n_o(lled_n), .loop_led_n_o(pled_n)
    );
    lcs_dac_model u_dac (.clk_i(clk_i), .rst_i(rst_i), .code_i(sp), .ua_o(ua));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        if (n >= 20) begin
            $display("MISMATCH bus ack exp 1 got %0h", ack);
            err_count++;
            give_verdict();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic put(input logic [31:0] v);
        @(posedge clk_i);
        acq <= '{1'b1, 17'h07530, v};
        @(posedge clk_i);
        acq.valid <= 1'b0;
    endtask
    task automatic wait_ua(input logic [15:0] ex, input string nm);
        int n;
        n = 0;
        while (ua !== ex && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        `CHK(nm, ex, ua)
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        `CHK("setpoint", CUR_LOW, sp)
        `CHK("link cfg", 14'h1301, lcfg)
        `CHK("led link", 1'b1, lled_n)
        `CHK("led loop", 1'b1, pled_n)
        wb(1'b0, OFS_RHI, 32'h0);
        `CHK("range hi", RST_RHI, q)
    endtask
    task automatic t_regs();
        wb(1'b1, OFS_POLL, 32'h15);
        wb(1'b1, OFS_POLL, 32'h41);
        wb(1'b0, OFS_POLL, 32'h0);
        `CHK("poll", 32'h15, q)
        wb(1'b1, OFS_POLL, 32'h0);
        wb(1'b1, OFS_LINK, 32'h0a05);
        wb(1'b0, OFS_LINK, 32'h0);
        `CHK("link cfg", 14'h0a05, lcfg)
        wb(1'b0, 8'hfc, 32'h0);
        `CHK("unmapped", 32'h0, q)
    endtask
    task automatic t_range();
        logic [31:0] pv [6] = '{32'h1388, 32'h09c4, 32'h0, 32'h2710, 32'h2711, 32'hffffffff};
        logic [15:0] ex [6] = '{16'h2ee0, 16'h1f40, CUR_LOW, CUR_HIGH, CUR_SAT_HI, CUR_SAT_LO};
        wb(1'b1, 8'h40, 32'h7530);
        foreach (pv[i]) begin
            put(pv[i]);
            repeat (2) @(posedge clk_i);
            `CHK("primary", pv[i], dyn.primary_variable)
            wait_ua(ex[i], "setpoint");
        end
    endtask
    task automatic t_md();
        put(32'h2711);
        wait_ua(CUR_SAT_HI, "over");
        wb(1'b1, OFS_POLL, 32'h3f);
        repeat (4) @(posedge clk_i);
        `CHK("multidrop", CUR_MULTI, ua)
        wb(1'b1, OFS_CTRL, 32'h1);
        fault <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK("alarm high", CUR_ALM_HI, ua)
        wb(1'b0, OFS_STAT, 32'h0);
        `CHK("status", {13'h0, 2'h2, 1'b1, CUR_ALM_HI}, q)
        wb(1'b1, OFS_CTRL, 32'h0);
        repeat (4) @(posedge clk_i);
        `CHK("alarm low", CUR_ALM_LO, ua)
        fault <= 1'b0;
        wb(1'b1, OFS_POLL, 32'h0);
        wait_ua(CUR_SAT_HI, "restore");
    endtask
    task automatic t_map();
        wb(1'b1, OFS_STORE, 32'h08);
        `CHK("store cfg", 5'h08, scfg)
        put(32'h11223344);
        wb(1'b1, OFS_MAP, 32'h3207);
        wb(1'b0, OFS_MAP, 32'h0);
        `CHK("map", 32'h3200, q)
        `CHK("second", 32'h44332211, dyn.second_variable)
        wb(1'b0, OFS_PV, 32'h0);
        `CHK("primary reg", 32'h44332211, q)
        wb(1'b0, 8'h60, 32'h0);
        `CHK("slot value", 32'h44332211, q)
        wb(1'b1, 8'h44, 32'h10000);
        wb(1'b1, 8'h44, 32'h10001);
        wb(1'b0, 8'h44, 32'h0);
        `CHK("source", 32'h10000, q)
    endtask
    task automatic t_led();
        @(posedge clk_i);
        lact <= 1'b1;
        pact <= 1'b1;
        @(posedge clk_i);
        lact <= 1'b0;
        pact <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK("led link on", 1'b0, lled_n)
        `CHK("led loop on", 1'b0, pled_n)
        repeat (12) @(posedge clk_i);
        `CHK("led link off", 1'b1, lled_n)
        `CHK("led loop off", 1'b1, pled_n)
    endtask
    initial begin
        repeat (50000) @(posedge clk_i);
        $display("MISMATCH run time exp done got timeout");
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_regs();
        t_range();
        t_md();
        t_map();
        t_led();
        give_verdict();
    end
endmodule
`default_nettype wire
